// ===== logic/slpg_top.sv
// Purpose: Dual-colour status LED pattern generator with activity indicator
// Assumes: Inputs synchronous to clk_i; Wishbone classic slave, 32-bit data
// Notes: Patterns are phase tables walked on a millisecond tick
//
// Contract
// (R01) Single-colour 2 Hz flash: lit 250 ms, dark 250 ms, repeat.
// (R02) Two-colour 2 Hz flash: first colour 250 ms, second 250 ms, repeat.
// (R03) One green per 3 s: green 250 ms, then orange 2.75 s.
// (R04) Two green per 3 s: green, orange, green 250 ms each, orange 2.25 s.
// (R05) Three green per 3 s: five 250 ms phases, then orange 1.75 s.
// (R06) One orange per 3 s: orange 250 ms, then green 2.75 s.
// (R07) Two orange per 3 s: orange, green, orange 250 ms each, green 2.25 s.
// (R08) High traffic: activity indicator toggles near 10 Hz, 50 ms lit, 50 ms dark.
// (R09) Low traffic: activity pulses follow actual frame arrivals, irregular timing.
// (R10) CAN operational: green held steadily lit.
// (R11) CAN pre-operational: green blinks at 2.5 Hz.
// (R12) 2.5 Hz blink: lit 200 ms, dark 200 ms, repeating.
// (R13) CAN stopped: green shows single flash.
// (R14) Single flash: lit 200 ms, then dark 1000 ms, repeating.
// (R15) Error counter at warning level: red shows single flash.
// (R16) Error control event occurred: red shows double flash.
// (R17) Double flash: lit 200, dark 200, lit 200, dark 1000 ms, repeating.
// (R18) Bus-off: red held steadily lit.
// (R19) During reset or without configuration both colours stay dark.
// (R20) Durations counted in millisecond ticks; pattern change restarts at first phase.
// (R21) Priority: bus-off, then error control, then warning, then green states.
//
// Local design decisions: the register addresses and register access over Wishbone.

module slpg_top #(
	parameter int unsigned TICK_CYCLES = slpg_pkg::TICK_CYCLES
) (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic frame_pulse_i,
	output logic red_o,
	output logic green_o,
	output logic act_o
);

	// ****************************************
	// Registers
	// ****************************************
	logic [2:0] ctrl;
	logic [7:0] eth;
	logic [4:0] can;
	logic bus_req;
	logic wr_en;

	assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign wr_en = bus_req && wb_we_i && wb_sel_i[0];

	// One wait state: ack follows the request by one edge, then drops
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= bus_req;
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			ctrl <= slpg_pkg::CTRL_RESET;
			eth <= slpg_pkg::ETH_RESET;
			can <= slpg_pkg::CAN_RESET;
		end else if (wr_en) begin
			case (wb_adr_i)
				slpg_pkg::ADR_CTRL: begin
					ctrl <= wb_dat_i[2:0];
				end
				slpg_pkg::ADR_ETH: begin
					eth <= wb_dat_i[7:0];
				end
				slpg_pkg::ADR_CAN: begin
					can <= wb_dat_i[4:0];
				end
				default: begin
				end
			endcase
		end
	end

	// ****************************************
	// Millisecond tick
	// ****************************************
	logic [31:0] div_cnt;
	logic ms_tick;

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			div_cnt <= 32'h0;
			ms_tick <= 1'b0;
		end else if (div_cnt == TICK_CYCLES - 1) begin
			div_cnt <= 32'h0;
			ms_tick <= 1'b1; // R20
		end else begin
			div_cnt <= div_cnt + 32'h1;
			ms_tick <= 1'b0;
		end
	end

	// ****************************************
	// Pattern selection
	// ****************************************
	slpg_pkg::slpg_pat_t next_pat;
	slpg_pkg::slpg_nmt_t nmt;

	assign nmt = slpg_pkg::slpg_nmt_t'(can[slpg_pkg::CAN_NMT_LSB +: 2]);

	always_comb begin
		next_pat.shape = slpg_pkg::SH_STEADY;
		next_pat.col_a = slpg_pkg::COL_OFF;
		next_pat.col_b = slpg_pkg::COL_OFF;
		if (!ctrl[slpg_pkg::CTRL_CFG_BIT] || ctrl[slpg_pkg::CTRL_RST_BIT]) begin
			next_pat.shape = slpg_pkg::SH_STEADY; // R19
		end else if (!ctrl[slpg_pkg::CTRL_CAN_BIT]) begin
			// Ethernet slave set is software-chosen shape and colours
			next_pat = slpg_pkg::slpg_pat_t'(eth);
		end else if (can[slpg_pkg::CAN_BUSOFF_BIT]) begin
			next_pat.col_a = slpg_pkg::COL_RED; // R18 R21
		end else if (can[slpg_pkg::CAN_ERRCTL_BIT]) begin
			next_pat.shape = slpg_pkg::SH_DFLASH; // R16 R21
			next_pat.col_a = slpg_pkg::COL_RED;
		end else if (can[slpg_pkg::CAN_WARN_BIT]) begin
			next_pat.shape = slpg_pkg::SH_SFLASH; // R15 R21
			next_pat.col_a = slpg_pkg::COL_RED;
		end else begin
			case (nmt)
				slpg_pkg::NMT_OPER: begin
					next_pat.col_a = slpg_pkg::COL_GREEN; // R10
				end
				slpg_pkg::NMT_PREOP: begin
					next_pat.shape = slpg_pkg::SH_BLINK; // R11
					next_pat.col_a = slpg_pkg::COL_GREEN;
				end
				slpg_pkg::NMT_STOPPED: begin
					next_pat.shape = slpg_pkg::SH_SFLASH; // R13
					next_pat.col_a = slpg_pkg::COL_GREEN;
				end
				default: begin
					next_pat.col_a = slpg_pkg::COL_OFF;
				end
			endcase
		end
	end

	// ****************************************
	// Phase tables
	// ****************************************
	function automatic slpg_pkg::slpg_phase_t phase_of(input slpg_pkg::slpg_shape_t shape, input logic [2:0] idx);
		slpg_pkg::slpg_phase_t ph;
		logic [2:0] n_last;
		slpg_pkg::slpg_ms_t rest;
		ph.use_b = 1'b0;
		ph.last = 1'b1;
		ph.dur = slpg_pkg::FLASH_MS;
		n_last = 3'h1;
		rest = slpg_pkg::REST_N1_MS;
		case (shape)
			slpg_pkg::SH_FLASH2: begin
				ph.use_b = idx[0]; // R01 R02
				ph.last = idx[0];
				ph.dur = slpg_pkg::FLASH_MS;
			end
			slpg_pkg::SH_N1, slpg_pkg::SH_N2, slpg_pkg::SH_N3: begin
				if (shape == slpg_pkg::SH_N2) begin
					n_last = 3'h3; // R04 R07
					rest = slpg_pkg::REST_N2_MS;
				end else if (shape == slpg_pkg::SH_N3) begin
					n_last = 3'h5; // R05
					rest = slpg_pkg::REST_N3_MS;
				end else begin
					n_last = 3'h1; // R03 R06
					rest = slpg_pkg::REST_N1_MS;
				end
				ph.use_b = idx[0];
				ph.last = (idx == n_last);
				ph.dur = (idx == n_last) ? rest : slpg_pkg::FLASH_MS;
			end
			slpg_pkg::SH_BLINK: begin
				ph.use_b = idx[0]; // R12
				ph.last = idx[0];
				ph.dur = slpg_pkg::BLINK_MS;
			end
			slpg_pkg::SH_SFLASH: begin
				ph.use_b = idx[0]; // R14
				ph.last = idx[0];
				ph.dur = idx[0] ? slpg_pkg::LONG_OFF_MS : slpg_pkg::BLINK_MS;
			end
			slpg_pkg::SH_DFLASH: begin
				ph.use_b = idx[0]; // R17
				ph.last = (idx == 3'h3);
				ph.dur = (idx == 3'h3) ? slpg_pkg::LONG_OFF_MS : slpg_pkg::BLINK_MS;
			end
			default: begin
				ph.use_b = 1'b0;
				ph.last = 1'b1;
				ph.dur = slpg_pkg::FLASH_MS;
			end
		endcase
		return ph;
	endfunction

	// ****************************************
	// Pattern engine
	// ****************************************
	slpg_pkg::slpg_pat_t pat;
	logic [2:0] phase_idx;
	slpg_pkg::slpg_ms_t ms_cnt;
	slpg_pkg::slpg_phase_t cur_ph;
	slpg_pkg::slpg_col_t cur_col;

	assign cur_ph = phase_of(pat.shape, phase_idx);
	assign cur_col = cur_ph.use_b ? pat.col_b : pat.col_a;

	// Restart keeps a new state visible from its first phase, not mid-cycle
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			pat <= '0;
			phase_idx <= 3'h0;
			ms_cnt <= '0;
		end else if (next_pat != pat) begin
			pat <= next_pat; // R20
			phase_idx <= 3'h0;
			ms_cnt <= '0;
		end else if (ms_tick) begin
			if (ms_cnt == cur_ph.dur - 12'h001) begin
				ms_cnt <= '0; // R20
				phase_idx <= cur_ph.last ? 3'h0 : phase_idx + 3'h1;
			end else begin
				ms_cnt <= ms_cnt + 12'h001;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			red_o <= 1'b0; // R19
			green_o <= 1'b0;
		end else begin
			red_o <= cur_col[1];
			green_o <= cur_col[0];
		end
	end

	// ****************************************
	// Activity indicator
	// ****************************************
	typedef enum logic [1:0] {
		ACT_IDLE = 2'b00,
		ACT_ON = 2'b01,
		ACT_OFF = 2'b10
	} slpg_act_t;

	slpg_act_t act_state;
	slpg_pkg::slpg_ms_t act_cnt;
	logic act_pend;
	logic act_done;

	assign act_done = ms_tick && (act_cnt == slpg_pkg::FLICKER_MS - 12'h001);

	// Frames seen while a flicker runs are folded into one pending flag
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			act_pend <= 1'b0;
		end else if (frame_pulse_i && act_state != ACT_IDLE) begin
			act_pend <= 1'b1;
		end else if (act_state == ACT_OFF && act_done) begin
			act_pend <= 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			act_state <= ACT_IDLE;
			act_cnt <= '0;
		end else begin
			case (act_state)
				ACT_IDLE: begin
					act_cnt <= '0;
					if (frame_pulse_i) begin
						act_state <= ACT_ON; // R09
					end
				end
				ACT_ON: begin
					if (act_done) begin
						act_cnt <= '0; // R08
						act_state <= ACT_OFF;
					end else if (ms_tick) begin
						act_cnt <= act_cnt + 12'h001;
					end
				end
				ACT_OFF: begin
					if (act_done) begin
						act_cnt <= '0;
						act_state <= (act_pend || frame_pulse_i) ? ACT_ON : ACT_IDLE; // R08 R09
					end else if (ms_tick) begin
						act_cnt <= act_cnt + 12'h001;
					end
				end
				default: begin
					act_state <= ACT_IDLE;
					act_cnt <= '0;
				end
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			act_o <= 1'b0;
		end else begin
			act_o <= (act_state == ACT_ON);
		end
	end

	// ****************************************
	// Read data
	// ****************************************
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			wb_dat_o <= 32'h0;
		end else if (bus_req && !wb_we_i) begin
			case (wb_adr_i)
				slpg_pkg::ADR_CTRL: begin
					wb_dat_o <= {29'h0, ctrl};
				end
				slpg_pkg::ADR_ETH: begin
					wb_dat_o <= {24'h0, eth};
				end
				slpg_pkg::ADR_CAN: begin
					wb_dat_o <= {27'h0, can};
				end
				slpg_pkg::ADR_STAT: begin
					wb_dat_o <= {22'h0, phase_idx, pat.shape, act_o, red_o, green_o};
				end
				default: begin
					wb_dat_o <= 32'h0;
				end
			endcase
		end
	end

endmodule

// ===== logic/slpg_pkg.sv
// Purpose: Shared constants and types of the status LED pattern generator
// Assumes: 40 MHz system clock, classic Wishbone register access
// Notes: Colour code is {red, green}; both lit shows orange

package slpg_pkg;

	// ****************************************
	// Timing
	// ****************************************
	localparam int unsigned CLK_HZ = 40_000_000;
	localparam int unsigned MS_PER_S = 1000;
	localparam int unsigned TICK_CYCLES = CLK_HZ / MS_PER_S;

	typedef logic [11:0] slpg_ms_t;

	localparam slpg_ms_t FLASH_MS = 12'h0fa;
	localparam slpg_ms_t REST_N1_MS = 12'habe;
	localparam slpg_ms_t REST_N2_MS = 12'h8ca;
	localparam slpg_ms_t REST_N3_MS = 12'h6d6;
	localparam slpg_ms_t BLINK_MS = 12'h0c8;
	localparam slpg_ms_t LONG_OFF_MS = 12'h3e8;
	localparam slpg_ms_t FLICKER_MS = 12'h032;

	// ****************************************
	// Pattern description
	// ****************************************
	typedef enum logic [1:0] {
		COL_OFF = 2'b00,
		COL_GREEN = 2'b01,
		COL_RED = 2'b10,
		COL_ORANGE = 2'b11
	} slpg_col_t;

	typedef enum logic [3:0] {
		SH_STEADY = 4'h0,
		SH_FLASH2 = 4'h1,
		SH_N1 = 4'h2,
		SH_N2 = 4'h3,
		SH_N3 = 4'h4,
		SH_BLINK = 4'h5,
		SH_SFLASH = 4'h6,
		SH_DFLASH = 4'h7
	} slpg_shape_t;

	typedef struct packed {
		slpg_col_t col_b;
		slpg_col_t col_a;
		slpg_shape_t shape;
	} slpg_pat_t;

	typedef struct packed {
		logic use_b;
		logic last;
		slpg_ms_t dur;
	} slpg_phase_t;

	typedef enum logic [1:0] {
		NMT_NONE = 2'b00,
		NMT_PREOP = 2'b01,
		NMT_OPER = 2'b10,
		NMT_STOPPED = 2'b11
	} slpg_nmt_t;

	// ****************************************
	// Register map
	// ****************************************
	localparam logic [7:0] ADR_CTRL = 8'h00;
	localparam logic [7:0] ADR_ETH = 8'h04;
	localparam logic [7:0] ADR_CAN = 8'h08;
	localparam logic [7:0] ADR_STAT = 8'h0c;

	localparam int unsigned CTRL_CFG_BIT = 0;
	localparam int unsigned CTRL_CAN_BIT = 1;
	localparam int unsigned CTRL_RST_BIT = 2;
	localparam int unsigned CAN_NMT_LSB = 0;
	localparam int unsigned CAN_WARN_BIT = 2;
	localparam int unsigned CAN_ERRCTL_BIT = 3;
	localparam int unsigned CAN_BUSOFF_BIT = 4;

	localparam logic [2:0] CTRL_RESET = 3'h0;
	localparam logic [7:0] ETH_RESET = 8'h00;
	localparam logic [4:0] CAN_RESET = 5'h00;

endpackage

// ===== test/slpg_props.sv
// Purpose: Port-level checks of slpg_top
// Assumes: TICK_CYCLES equals the instance value
// Notes: Bound from the bench top file
module slpg_props #(
	parameter int unsigned TICK_CYCLES = 4
) (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic frame_pulse_i,
	input wire logic red_o,
	input wire logic green_o,
	input wire logic act_o
);
	// ****************************************
	// Helpers
	// ****************************************
	// First phase after a restart may lose one tick
	localparam int MIN_RUN = 199 * TICK_CYCLES;
	logic [15:0] col_run;
	logic [15:0] act_run;
	logic [15:0] idle_run;
	default clocking @(posedge clk_i); endclocking
	default disable iff (reset_i);
	always_ff @(posedge clk_i) begin
		if (reset_i || $changed({red_o, green_o})) begin
			col_run <= 16'h0001;
		end else if (col_run != 16'hffff) begin
			col_run <= col_run + 16'h0001;
		end
	end
	always_ff @(posedge clk_i) begin
		act_run <= (act_o && !reset_i) ? act_run + 16'h0001 : 16'h0000;
	end
	always_ff @(posedge clk_i) begin
		if (reset_i || frame_pulse_i) begin
			idle_run <= 16'h0000;
		end else if (idle_run != 16'hffff) begin
			idle_run <= idle_run + 16'h0001;
		end
	end
	// ****************************************
	// Assertions
	// ****************************************
	a_ack_one_wait: assert property ((wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o) else $error("ack late");
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
	a_ack_cause: assert property (wb_ack_o |-> $past(wb_stb_i)) else $error("ack without request");
	a_dark_reset: assert property ($past(reset_i) |-> !red_o && !green_o && !act_o) else $error("lit after reset");
	a_act_on_len: assert property ($fell(act_o) |-> act_run >= 49 * TICK_CYCLES && act_run <= 50 * TICK_CYCLES)
		else $error("activity on time wrong");
	a_act_cause: assert property ($rose(act_o) |-> idle_run <= 100 * TICK_CYCLES + 4)
		else $error("activity without frame");
	a_phase_min: assert property ($changed({red_o, green_o}) && !$past(wb_ack_o) && !$past(wb_ack_o, 2)
		&& !$past(wb_ack_o, 3) |-> col_run >= MIN_RUN) else $error("phase too short");
	a_unmapped_zero: assert property (wb_ack_o && !wb_we_i && (|wb_adr_i[7:4] || |wb_adr_i[1:0])
		|-> wb_dat_o == 32'h0) else $error("unmapped read not zero");
	a_upper_zero: assert property (wb_ack_o && !wb_we_i |-> wb_dat_o[31:10] == 22'h0) else $error("upper bits set");
	c_act: cover property ($fell(act_o));
	c_orange: cover property ($changed({red_o, green_o}) && red_o && green_o);
	c_write: cover property (wb_ack_o && wb_we_i);
endmodule

// ===== test/slpg_led_obs.sv
// Purpose: Eye on the red/green LED
// Assumes: Drives sampled on clk_i
// Notes: Reports each finished run of one colour
module slpg_led_obs (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic red_i,
	input wire logic green_i,
	output logic [1:0] col_o,
	output logic [1:0] prev_o,
	output logic [15:0] len_o,
	output logic [15:0] nchg_o
);
	logic [15:0] run;
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			col_o <= 2'h0;
			prev_o <= 2'h0;
			len_o <= 16'h0;
			nchg_o <= 16'h0;
			run <= 16'h0;
		end else if ({red_i, green_i} != col_o) begin
			prev_o <= col_o;
			len_o <= run;
			col_o <= {red_i, green_i};
			nchg_o <= nchg_o + 16'h1;
			run <= 16'h1;
		end else begin
			run <= run + 16'h1;
		end
	end
endmodule

// ===== test/status_led_pattern_generator_test.sv
// Purpose: Self-checking bench of slpg_top
// Assumes: Tick shortened to TK cycles per ms
// Notes: Phase lengths are exact except the first
module status_led_pattern_generator_test;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int TK = 2;
	logic clk_i, reset_i, cyc, stb, we, fp;
	logic [7:0] adr;
	logic [3:0] sel;
	logic [31:0] dat, dat_o, rd;
	logic ack, red, green, act;
	logic [1:0] col, prev;
	logic [15:0] len, nchg;
	int error_cnt = 0;
	int checked = 0;
	slpg_top #(.TICK_CYCLES(TK)) slpg_top_inst (.clk_i(clk_i), .reset_i(reset_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
		.frame_pulse_i(fp), .red_o(red), .green_o(green), .act_o(act));
	slpg_led_obs slpg_led_obs_inst (.clk_i(clk_i), .reset_i(reset_i), .red_i(red), .green_i(green),
		.col_o(col), .prev_o(prev), .len_o(len), .nchg_o(nchg));
	// ****************************************
	// Shared tasks
	// ****************************************
	task stop_test;
		$display("checks %0d errors %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		int n;
		n = 0;
		@(posedge clk_i);
		{cyc, stb, we, adr, dat, sel} <= {2'b11, w, a, d, s};
		do begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'b1 && n < 50);
		rd = dat_o;
		{cyc, stb, we} <= 3'b000;
		if (n >= 50) begin
			check("ack wait", 0, 1);
			stop_test();
		end
		@(posedge clk_i);
	endtask
	task wait_chg;
		int i;
		logic [15:0] n0;
		n0 = nchg;
		i = 0;
		while (nchg === n0) begin
			@(posedge clk_i);
			i++;
			if (i > 3000 * TK) begin
				check("change wait", 0, 1);
				stop_test();
			end
		end
	endtask
	// Phase 0 may be short, so it is skipped
	task runs(input logic [7:0] a, input logic [7:0] v, input int n, input int c [6], input int ms [6]);
		wb(1, a, {24'h0, v}, 4'h1);
		repeat (4) @(posedge clk_i);
		check("first colour", {30'h0, col}, c[n - 1]);
		wait_chg();
		for (int k = 0; k < n; k++) begin
			wait_chg();
			check("colour", {30'h0, prev}, c[k]);
			check("length", {16'h0, len}, ms[k] * TK);
		end
	endtask
	task steady(input logic [7:0] a, input logic [7:0] v, input logic [1:0] c);
		logic [15:0] n0;
		wb(1, a, {24'h0, v}, 4'h1);
		repeat (4) @(posedge clk_i);
		n0 = nchg;
		repeat (600 * TK) @(posedge clk_i);
		check("steady", {nchg, 14'h0, col}, {n0, 14'h0, c});
	endtask
	task act_len(input logic lv, output int n);
		n = 0;
		while (act === lv && n < 400) begin
			@(posedge clk_i);
			n++;
		end
	endtask
	task pulse;
		@(posedge clk_i);
		fp <= 1'b1;
		@(posedge clk_i);
		fp <= 1'b0;
	endtask
	// ****************************************
	// Scenarios
	// ****************************************
	task t_regs;
		for (int i = 0; i < 16; i += 4) begin
			wb(0, i[7:0], 32'h0, 4'hf);
			check("reset value", rd, 32'h0);
		end
		wb(1, 8'h00, 32'h1, 4'he);
		wb(1, 8'h0c, 32'h3ff, 4'hf);
		wb(1, 8'h10, 32'hff, 4'hf);
		wb(0, 8'h00, 32'h0, 4'hf);
		check("sel masked", rd, 32'h0);
		wb(0, 8'h0c, 32'h0, 4'hf);
		check("status read only", rd, 32'h0);
		wb(0, 8'h10, 32'h0, 4'hf);
		check("unmapped", rd, 32'h0);
		wb(1, 8'h04, 32'ha5, 4'hf);
		wb(0, 8'h04, 32'h0, 4'hf);
		check("eth rw", rd, 32'ha5);
		check("dark", {red, green}, 2'h0);
	endtask
	task t_eth;
		wb(1, 8'h00, 32'h1, 4'hf);
		runs(8'h04, 8'h11, 2, '{0, 1, 0, 0, 0, 0}, '{250, 250, 0, 0, 0, 0});
		runs(8'h04, 8'h61, 2, '{1, 2, 0, 0, 0, 0}, '{250, 250, 0, 0, 0, 0});
		runs(8'h04, 8'hd2, 2, '{3, 1, 0, 0, 0, 0}, '{2750, 250, 0, 0, 0, 0});
		runs(8'h04, 8'hd3, 4, '{3, 1, 3, 1, 0, 0}, '{250, 250, 2250, 250, 0, 0});
		runs(8'h04, 8'hd4, 6, '{3, 1, 3, 1, 3, 1}, '{250, 250, 250, 250, 1750, 250});
		runs(8'h04, 8'h72, 2, '{1, 3, 0, 0, 0, 0}, '{2750, 250, 0, 0, 0, 0});
		runs(8'h04, 8'h73, 4, '{1, 3, 1, 3, 0, 0}, '{250, 250, 2250, 250, 0, 0});
	endtask
	// Reset in mid-run while red is lit
	task t_rst;
		@(posedge clk_i);
		reset_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		check("reset dark", {act, red, green}, 3'h0);
		reset_i <= 1'b0;
		@(posedge clk_i);
		wb(0, 8'h08, 32'h0, 4'hf);
		check("reset clears", rd, 32'h0);
	endtask
	task t_can;
		wb(1, 8'h00, 32'h3, 4'hf);
		steady(8'h08, 8'h02, 2'h1);
		runs(8'h08, 8'h01, 2, '{0, 1, 0, 0, 0, 0}, '{200, 200, 0, 0, 0, 0});
		runs(8'h08, 8'h03, 2, '{0, 1, 0, 0, 0, 0}, '{1000, 200, 0, 0, 0, 0});
		runs(8'h08, 8'h06, 2, '{0, 2, 0, 0, 0, 0}, '{1000, 200, 0, 0, 0, 0});
		runs(8'h08, 8'h0e, 4, '{0, 2, 0, 2, 0, 0}, '{200, 200, 1000, 200, 0, 0});
		steady(8'h08, 8'h1e, 2'h2);
		t_rst();
		steady(8'h00, 8'h07, 2'h0);
		steady(8'h00, 8'h02, 2'h0);
	endtask
	task t_act;
		int n;
		pulse();
		act_len(0, n);
		check("act start", n <= 4, 1);
		pulse();
		act_len(1, n);
		check("act first on", n <= 50 * TK, 1);
		act_len(0, n);
		check("act off", n, 50 * TK);
		act_len(1, n);
		check("act on", n, 50 * TK);
		act_len(0, n);
		check("act idle", n, 400);
	endtask
	initial begin
		clk_i = 1'b0;
		forever #12.5 clk_i = ~clk_i;
	end
	initial begin
		{reset_i, cyc, stb, we, fp, adr, sel, dat} = {1'b1, 48'h0};
		repeat (3) @(posedge clk_i);
		reset_i <= 1'b0;
		@(posedge clk_i);
		t_regs();
		t_act();
		t_eth();
		t_can();
		stop_test();
	end
endmodule
bind slpg_top slpg_props #(.TICK_CYCLES(TICK_CYCLES)) slpg_props_inst (.clk_i(clk_i), .reset_i(reset_i),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
	.wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .frame_pulse_i(frame_pulse_i),
	.red_o(red_o), .green_o(green_o), .act_o(act_o));
